// ---- sim/fsr_bank_tb.sv ----
// self-checking bench for the flash status register bank
`timescale 1ns/1ps
`default_nettype none
module fsr_bank_tb;
  // table row: optional leading command, frame, status expected after
  typedef struct packed
  {
    logic [7:0]  pre;
    logic [7:0]  op;
    logic [1:0]  n;
    logic [23:0] wd;
    logic [23:0] exp;
  } fsr_row_s;

  // rows; a leading command of 00 means none
  localparam fsr_row_s ROWS [9] = '{
    '{8'h00, 8'h01, 2'd1, 24'h0000FC, 24'h400000},
    '{8'h00, 8'h06, 2'd0, 24'h000000, 24'h400002},
    '{8'h00, 8'h04, 2'd0, 24'h000000, 24'h400000},
    '{8'h00, 8'h50, 2'd0, 24'h000000, 24'h400000},
    '{8'h50, 8'h01, 2'd3, 24'hA042FC, 24'hA042FC},
    '{8'h50, 8'h01, 2'd1, 24'h000003, 24'hA04200},
    '{8'h06, 8'h01, 2'd2, 24'h000240, 24'hA00240},
    '{8'h06, 8'h01, 2'd1, 24'h000040, 24'hA00242},
    '{8'h00, 8'h04, 2'd0, 24'h000000, 24'hA00240}};

  // design pins
  logic        i_clk, i_rst, i_sck, i_cs_n, i_si, o_so, o_so_oe;
  logic        i_hold_rst_n, o_hold_active, o_pin_reset, o_busy, o_write_allowed;
  logic        i_op_start, i_op_erase, i_op_done, i_op_fail, o_quad_enable;
  logic [4:0]  o_block_protect;
  logic [1:0]  o_drive_strength;
  logic        o_cmd_valid, o_suspend, o_resume, o_abort, o_complement;
  logic [7:0]  o_cmd_code, code_seen;
  logic [2:0]  o_info_locks;
  // notices to the array engine seen so far
  int          susp_seen, resume_seen, cmd_seen, abort_seen;
  // bookkeeping
  int          bad_count, checks, cycles;
  logic [23:0] rd;

  fsr_bank fsr_bank_inst (.i_clk(i_clk), .i_rst(i_rst), .i_sck(i_sck), .i_cs_n(i_cs_n),
    .i_si(i_si), .o_so(o_so), .o_so_oe(o_so_oe), .i_hold_rst_n(i_hold_rst_n),
    .o_hold_active(o_hold_active), .o_pin_reset(o_pin_reset), .i_op_start(i_op_start),
    .i_op_erase(i_op_erase), .i_op_done(i_op_done), .i_op_fail(i_op_fail),
    .o_cmd_valid(o_cmd_valid), .o_cmd_code(o_cmd_code), .o_suspend(o_suspend),
    .o_resume(o_resume), .o_abort(o_abort),
    .o_busy(o_busy), .o_write_allowed(o_write_allowed), .o_block_protect(o_block_protect),
    .o_complement(o_complement), .o_info_locks(o_info_locks), .o_quad_enable(o_quad_enable),
    .o_drive_strength(o_drive_strength));

  fsr_host_model fsr_host_model_inst (.i_clk(i_clk), .o_sck(i_sck), .o_cs_n(i_cs_n),
    .o_si(i_si), .i_so(o_so), .i_so_oe(o_so_oe));

  // 10 MHz system clock
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // compare and count
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // a frame whose read-back is not needed
  task automatic frame(input logic [7:0] op, input int n, input logic [23:0] wd);
    fsr_host_model_inst.xfer(op, n, wd, rd);
  endtask

  // read all three registers and compare
  task automatic status(input logic [23:0] exp);
    fsr_host_model_inst.xfer(8'h05, 3, 24'h000000, rd);
    check(rd, exp);
  endtask

  // array engine strobe for one cycle
  task automatic engine(input logic start, input logic erase, input logic done,
                        input logic fail);
    @(negedge i_clk);
    i_op_start = start;
    i_op_erase = erase;
    i_op_done  = done;
    i_op_fail  = fail;
    @(negedge i_clk);
    i_op_start = 1'b0;
    i_op_done  = 1'b0;
    @(negedge i_clk);
  endtask

  // count one-cycle notices mid-cycle, where each stands exactly once
  always @(negedge i_clk)
  begin
    if (o_suspend === 1'b1)
      susp_seen++;
    if (o_resume === 1'b1)
      resume_seen++;
    if (o_abort === 1'b1)
      abort_seen++;
    if (o_cmd_valid === 1'b1)
    begin
      cmd_seen++;
      code_seen = o_cmd_code;
    end
  end

  // verdict and end of run
  task automatic results;
    if (bad_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // hang guard, generous over the expected 9k cycles
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      bad_count++;
      results();
    end
  end

  initial
  begin
    i_rst        = 1'b1;
    i_hold_rst_n = 1'b1;
    i_op_start   = 1'b0;
    i_op_erase   = 1'b0;
    i_op_done    = 1'b0;
    i_op_fail    = 1'b0;
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    check(24'(o_drive_strength), 24'h000002);
    // ordinary command sequences from the table
    foreach (ROWS[k])
    begin
      if (ROWS[k].pre !== 8'h00)
        frame(ROWS[k].pre, 0, 24'h000000);
      frame(ROWS[k].op, ROWS[k].n, ROWS[k].wd);
      status(ROWS[k].exp);
    end
    check(24'({o_block_protect, o_quad_enable, o_drive_strength}), 24'h000085);
    // non-volatile write holds busy, then lands and drops the latch
    frame(8'h06, 0, 24'h000000);
    frame(8'h01, 1, 24'h000044);
    check(24'({o_busy, o_write_allowed}), 24'h000002);
    repeat (30) @(negedge i_clk);
    status(24'hA00244);
    // quad on: shared pin has no reset or hold function
    i_hold_rst_n = 1'b0;
    repeat (8) @(negedge i_clk);
    check(24'({o_pin_reset, o_hold_active}), 24'h000000);
    i_hold_rst_n = 1'b1;
    // volatile copy differs from the stored one until the pin reloads it
    frame(8'h50, 0, 24'h000000);
    frame(8'h01, 2, 24'h000044);
    status(24'hA00044);
    i_hold_rst_n = 1'b0;
    for (int t = 0; t < 10 && o_pin_reset !== 1'b1; t++) @(negedge i_clk);
    check(24'(o_pin_reset), 24'h000001);
    i_hold_rst_n = 1'b1;
    repeat (8) @(negedge i_clk);
    status(24'hA00244);
    // program: busy ignores disable, suspend and resume still act, then a failing finish
    frame(8'h06, 0, 24'h000000);
    check(24'(o_write_allowed), 24'h000001);
    engine(1'b1, 1'b0, 1'b0, 1'b0);
    check(24'(o_busy), 24'h000001);
    frame(8'h04, 0, 24'h000000);
    status(24'hA00247);
    frame(8'h75, 0, 24'h000000);
    status(24'hA00646);
    frame(8'h7A, 0, 24'h000000);
    status(24'hA00247);
    engine(1'b0, 1'b0, 1'b1, 1'b1);
    status(24'hA80244);
    // erase: suspended flag, then a clean finish clears the error
    frame(8'h06, 0, 24'h000000);
    engine(1'b1, 1'b1, 1'b0, 1'b0);
    frame(8'h75, 0, 24'h000000);
    status(24'hA88246);
    frame(8'h7A, 0, 24'h000000);
    engine(1'b0, 1'b1, 1'b1, 1'b0);
    status(24'hA00244);
    check(24'(susp_seen), 24'h000002);
    check(24'(resume_seen), 24'h000002);
    // lock bit sets once; a later write cannot take it back
    frame(8'h06, 0, 24'h000000);
    frame(8'h01, 2, 24'h004A44);
    repeat (30) @(negedge i_clk);
    check(24'({o_complement, o_info_locks}), 24'h000009);
    frame(8'h06, 0, 24'h000000);
    frame(8'h01, 2, 24'h000244);
    status(24'hA00A44);
    // a command not handled here goes on to the engine
    frame(8'hAB, 0, 24'h000000);
    check(24'({cmd_seen[7:0], code_seen}), 24'h0001AB);
    // soft reset passes while busy and aborts the running program
    frame(8'h06, 0, 24'h000000);
    engine(1'b1, 1'b0, 1'b0, 1'b0);
    frame(8'h66, 0, 24'h000000);
    frame(8'h99, 0, 24'h000000);
    check(24'(abort_seen), 24'h000001);
    status(24'hA00A44);
    // reset in mid-run returns both copies to their reset value
    i_rst = 1'b1;
    repeat (3) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    status(24'h400000);
    results();
  end
endmodule
`default_nettype wire

// ---- sim/fsr_host_model.sv ----
// host model: serial master that issues status frames in mode 0
`timescale 1ns/1ps
`default_nettype none
module fsr_host_model
(
  // clock reference for stepping the pins
  input  wire logic i_clk,
  // serial pins toward the device
  output var  logic o_sck,
  output var  logic o_cs_n,
  output var  logic o_si,
  input  wire logic i_so,
  input  wire logic i_so_oe
);
  // half link period in system clocks, 400 ns
  localparam int HALF = 4;

  // idle: link clock still, not selected
  initial
  begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end

  // wait a number of falling system clock edges
  task automatic gap(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // one frame: opcode then n data bytes, read bytes captured on each rise
  task automatic xfer(input logic [7:0] op, input int n, input logic [23:0] wd,
                      output logic [23:0] rd);
    logic [31:0] out;
    int          j;
    out = {op, wd[7:0], wd[15:8], wd[23:16]};
    rd  = 24'h000000;
    gap(1);
    o_cs_n = 1'b0;
    // msb first, one register per byte
    for (int i = 0; i < 8 * (n + 1); i++)
    begin
      o_si = out[31 - i];
      gap(HALF);
      o_sck = 1'b1;
      j = i - 8;
      // undriven output counts as unknown, never as a match
      if (j >= 0)
        rd[(j / 8) * 8 + 7 - (j % 8)] = i_so_oe ? i_so : 1'bx;
      gap(HALF);
      o_sck = 1'b0;
    end
    gap(HALF);
    o_cs_n = 1'b1;
    // released data line must not keep a stale level
    o_si = ~o_si;
    // cs high long enough for the synchroniser and the action
    gap(8);
  endtask
endmodule
`default_nettype wire

// ---- src/fsr_bank.sv ----
// status register bank of a serial flash, reached over its serial pins
`timescale 1ns/1ps
`default_nettype none
// How it works
// - identical status write skips internal write
// - first register: busy, latch, protect bits
// - busy bit read-only, one while busy
// - busy set during program, erase, non-volatile register writes
// - while busy only status, reset, suspend
// - suspend accepted during running program or erase
// - busy clears on finish, pass or fail
// - only 06h sets latch; latch gates writes
// - volatile status write never alters the latch
// - latch clears on disable or write completion
// - 50h then 01h writes volatile copy
// - protect bits volatile and non-volatile, writable
// - read status returns the volatile copy
// - second register: select, quad, suspend, locks
// - quad enable read/write, enables quad data
// - program-suspended flag read-only, volatile
// - erase-suspended flag read-only, volatile
// - lock bits one-time, set blocks programming
// - bit 19 error flag, rest read-only reserved
// - bits 21-22 select output drive strength
// - bit 23 selects hold or reset pin
// - suspend sets flag, resume clears it
// - pin function only while quad is off
// - drive code 10 means 50 percent default
module fsr_bank
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // serial pins, asynchronous to i_clk
  input  wire logic       i_sck,
  input  wire logic       i_cs_n,
  input  wire logic       i_si,
  output var  logic       o_so,
  output logic            o_so_oe,
  // shared hold or reset pin
  input  wire logic       i_hold_rst_n,
  output logic            o_hold_active,
  output logic            o_pin_reset,
  // array engine, same clock
  input  wire logic       i_op_start,
  input  wire logic       i_op_erase,
  input  wire logic       i_op_done,
  input  wire logic       i_op_fail,
  output var  logic       o_cmd_valid,
  output var  logic [7:0] o_cmd_code,
  output var  logic       o_suspend,
  output var  logic       o_resume,
  output var  logic       o_abort,
  // state seen by the rest of the device
  output logic            o_busy,
  output logic            o_write_allowed,
  output logic [4:0]      o_block_protect,
  output logic            o_complement,
  output logic [2:0]      o_info_locks,
  output logic            o_quad_enable,
  output logic [1:0]      o_drive_strength
);

  // synchroniser stages; stage one feeds only stage two
  logic                 sck_s1_q, sck_s2_q, sck_s3_q;
  logic                 cs_s1_q, cs_s2_q, cs_s3_q;
  logic                 si_s1_q, si_s2_q;
  logic                 hr_s1_q, hr_s2_q;
  // frame decode
  fsr_pkg::fsr_state_e  st_q;
  logic [2:0]           bit_cnt_q;
  logic [7:0]           rx_q, op_q, tx_q, rx_byte;
  logic                 skip_q;
  logic [1:0]           rd_idx_q, rd_sel, wcnt_q;
  logic [23:0]          wbuf_q, merged, cand, rd_word, sr_q, pend_q, nv_rdata;
  // control state
  logic                 wel_q, vwe_q, rsten_q;
  logic                 nv_busy_q;
  logic [7:0]           nv_cnt_q;
  logic                 op_run_q, op_erase_q, program_suspended_flag_q, erase_suspended_flag_q, err_q;
  // combinational helpers
  logic                 sck_rise, sck_fall, cs_rise, hold_on, byte_done;
  logic                 busy, exec, ok, wr_go, same, nv_go, vol_go, nv_done;
  logic                 op_fin, pin_rst, soft_rst, local_op;

  // two flops on every pin, third only for edge finding
  always_ff @(posedge i_clk)
  begin
    sck_s1_q <= i_sck;
    sck_s2_q <= sck_s1_q;
    sck_s3_q <= sck_s2_q;
    cs_s1_q  <= i_cs_n;
    cs_s2_q  <= cs_s1_q;
    cs_s3_q  <= cs_s2_q;
    si_s1_q  <= i_si;
    si_s2_q  <= si_s1_q;
    hr_s1_q  <= i_hold_rst_n;
    hr_s2_q  <= hr_s1_q;
  end

  // edges; the link clock is slow enough to be oversampled
  assign sck_rise = sck_s2_q & ~sck_s3_q;
  assign sck_fall = ~sck_s2_q & sck_s3_q;
  assign cs_rise  = cs_s2_q & ~cs_s3_q;
  assign hold_on  = ~sr_q[fsr_pkg::BIT_QUAD] & ~sr_q[fsr_pkg::BIT_PINSEL] & ~hr_s2_q;
  assign pin_rst  = ~sr_q[fsr_pkg::BIT_QUAD] & sr_q[fsr_pkg::BIT_PINSEL] & ~hr_s2_q;
  assign rx_byte  = {rx_q[6:0], si_s2_q};
  assign byte_done = sck_rise & ~hold_on & ~cs_s2_q & (bit_cnt_q == 3'h7);

  assign busy = nv_busy_q | (op_run_q & ~program_suspended_flag_q & ~erase_suspended_flag_q);
  // commands act when the frame closes
  assign exec = cs_rise & ((st_q == fsr_pkg::ST_SKIP) | (st_q == fsr_pkg::ST_WDATA));
  assign ok = ~busy | (op_q == fsr_pkg::OP_SUSPEND) | (op_q == fsr_pkg::OP_RESET_EN)
              | (op_q == fsr_pkg::OP_RESET);
  assign op_fin   = op_run_q & ~program_suspended_flag_q & ~erase_suspended_flag_q & i_op_done;
  assign soft_rst = pin_rst | (exec & rsten_q & (op_q == fsr_pkg::OP_RESET));
  assign local_op = (op_q == fsr_pkg::OP_WRITE_ENABLE) | (op_q == fsr_pkg::OP_WRITE_DISABLE)
                  | (op_q == fsr_pkg::OP_VOL_WRITE_EN) | (op_q == fsr_pkg::OP_WRITE_STATUS)
                  | (op_q == fsr_pkg::OP_SUSPEND) | (op_q == fsr_pkg::OP_RESUME)
                  | (op_q == fsr_pkg::OP_RESET_EN) | (op_q == fsr_pkg::OP_RESET);

  // frame state and bit shifter
  always_ff @(posedge i_clk)
  begin
    if (i_rst | pin_rst)
    begin
      st_q      <= fsr_pkg::ST_IDLE;
      bit_cnt_q <= 3'h0;
      rx_q      <= 8'h00;
      op_q      <= 8'h00;
    end
    else if (cs_s2_q)
    begin
      // deselected: realign to a byte boundary
      st_q      <= fsr_pkg::ST_IDLE;
      bit_cnt_q <= 3'h0;
    end
    else
    begin
      // hold freezes the shifter without losing position
      if (sck_rise & ~hold_on)
      begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        rx_q      <= rx_byte;
      end
      case (st_q)
        fsr_pkg::ST_IDLE:
          st_q <= fsr_pkg::ST_CMD;
        fsr_pkg::ST_CMD:
          if (byte_done)
          begin
            op_q <= rx_byte;
            if (rx_byte == fsr_pkg::OP_READ_STATUS)
              st_q <= fsr_pkg::ST_READ;
            else if (rx_byte == fsr_pkg::OP_WRITE_STATUS)
              st_q <= fsr_pkg::ST_WDATA;
            else
              st_q <= fsr_pkg::ST_SKIP;
          end
        fsr_pkg::ST_READ, fsr_pkg::ST_WDATA, fsr_pkg::ST_SKIP:
          st_q <= st_q;
        default:
          st_q <= fsr_pkg::ST_IDLE;
      endcase
    end
  end

  // write data bytes, first byte to register one
  always_ff @(posedge i_clk)
  begin
    if (i_rst | cs_s2_q)
      wcnt_q <= 2'h0;
    else if (byte_done & (st_q == fsr_pkg::ST_WDATA) & (wcnt_q != 2'h3))
    begin
      wbuf_q[{wcnt_q, 3'b000} +: 8] <= rx_byte;
      wcnt_q <= wcnt_q + 2'h1;
    end
  end

  // bytes not sent keep their present value
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_merge
      assign merged[8*g +: 8] = (wcnt_q > 2'(g)) ? wbuf_q[8*g +: 8] : sr_q[8*g +: 8];
    end
  endgenerate

  // only writable bits; locks only set
  assign cand = (merged & fsr_pkg::WRITE_MASK) | (sr_q & fsr_pkg::OTP_MASK);
  assign same   = (cand == sr_q);
  assign wr_go  = exec & ~busy & (op_q == fsr_pkg::OP_WRITE_STATUS) & (wcnt_q != 2'h0);
  assign nv_go  = wr_go & wel_q & ~same;
  assign vol_go = wr_go & ~wel_q & vwe_q & ~same;
  assign nv_done = nv_busy_q & (nv_cnt_q == 8'h01);

  always_ff @(posedge i_clk)
  begin
    if (i_rst | soft_rst)
    begin
      nv_busy_q <= 1'h0;
      nv_cnt_q  <= 8'h00;
    end
    else if (nv_go)
    begin
      nv_busy_q <= 1'h1;
      nv_cnt_q  <= 8'(fsr_pkg::NV_WRITE_CYC);
      pend_q    <= cand;
    end
    else if (nv_busy_q)
    begin
      nv_busy_q <= ~nv_done;
      nv_cnt_q  <= nv_cnt_q - 8'h01;
    end
  end

  // non-volatile copy, written at the end of the cycle
  fsr_nv_store u_nv
  (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_we    (nv_done),
    .i_wdata (pend_q),
    .o_rdata (nv_rdata)
  );

  // volatile copy; soft reset reloads from cells
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      sr_q <= fsr_pkg::SR_RESET;
    else if (soft_rst)
      sr_q <= nv_rdata;
    else if (nv_done)
      sr_q <= pend_q;
    else if (vol_go)
      sr_q <= cand;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst | soft_rst)
      wel_q <= 1'h0;
    else if (nv_done | op_fin)
      wel_q <= 1'h0;
    else if (exec & ~busy & (op_q == fsr_pkg::OP_WRITE_ENABLE))
      wel_q <= 1'h1;
    else if (exec & ~busy & (op_q == fsr_pkg::OP_WRITE_DISABLE))
      wel_q <= 1'h0;
  end

  // one-shot enables, dropped by the next accepted command other than a status read
  always_ff @(posedge i_clk)
  begin
    if (i_rst | soft_rst)
    begin
      vwe_q   <= 1'h0;
      rsten_q <= 1'h0;
    end
    else if (exec & ok)
    begin
      vwe_q   <= (op_q == fsr_pkg::OP_VOL_WRITE_EN);
      rsten_q <= (op_q == fsr_pkg::OP_RESET_EN);
    end
  end

  // program or erase run, suspend flags and error flag
  always_ff @(posedge i_clk)
  begin
    if (i_rst | soft_rst)
    begin
      op_run_q   <= 1'h0;
      op_erase_q <= 1'h0;
      program_suspended_flag_q     <= 1'h0;
      erase_suspended_flag_q     <= 1'h0;
      err_q      <= 1'h0;
    end
    else
    begin
      // engine may start only with latch set
      if (i_op_start & wel_q & ~busy)
      begin
        op_run_q   <= 1'h1;
        op_erase_q <= i_op_erase;
      end
      else if (op_fin)
      begin
        op_run_q <= 1'h0;
        err_q    <= i_op_fail;
      end
      if (exec & (op_q == fsr_pkg::OP_SUSPEND) & op_run_q & ~program_suspended_flag_q & ~erase_suspended_flag_q)
      begin
        program_suspended_flag_q <= ~op_erase_q;
        erase_suspended_flag_q <= op_erase_q;
      end
      else if (exec & (op_q == fsr_pkg::OP_RESUME) & ok & (program_suspended_flag_q | erase_suspended_flag_q))
      begin
        program_suspended_flag_q <= 1'h0;
        erase_suspended_flag_q <= 1'h0;
      end
    end
  end

  // one-cycle notices to the array engine
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_cmd_valid <= 1'h0;
      o_cmd_code  <= 8'h00;
      o_suspend   <= 1'h0;
      o_resume    <= 1'h0;
      o_abort     <= 1'h0;
    end
    else
    begin
      o_cmd_valid <= exec & ~busy & ~local_op;
      o_cmd_code  <= op_q;
      o_suspend   <= exec & (op_q == fsr_pkg::OP_SUSPEND) & op_run_q & ~program_suspended_flag_q & ~erase_suspended_flag_q;
      o_resume    <= exec & (op_q == fsr_pkg::OP_RESUME) & ok & (program_suspended_flag_q | erase_suspended_flag_q);
      o_abort     <= soft_rst & (op_run_q | nv_busy_q);
    end
  end

  // status word layout, reserved read zero
  assign rd_word = {sr_q[23:21], 1'h0, err_q, 3'h0, erase_suspended_flag_q, sr_q[14:11], program_suspended_flag_q,
                    sr_q[9:2], wel_q, busy};

  // read shifter, msb first, one register a byte
  assign rd_sel = (st_q == fsr_pkg::ST_READ) ? rd_idx_q : 2'h0;
  always_ff @(posedge i_clk)
  begin
    if (i_rst | soft_rst)
    begin
      tx_q     <= 8'h00;
      skip_q   <= 1'h0;
      rd_idx_q <= 2'h0;
    end
    else if (byte_done & (((st_q == fsr_pkg::ST_CMD) & (rx_byte == fsr_pkg::OP_READ_STATUS))
                          | (st_q == fsr_pkg::ST_READ)))
    begin
      // loaded at the byte boundary so polling sees live busy
      tx_q     <= rd_word[{rd_sel, 3'b000} +: 8];
      rd_idx_q <= (rd_sel == 2'h2) ? 2'h0 : rd_sel + 2'h1;
      skip_q   <= 1'h1;
    end
    else if (sck_fall & ~hold_on & (st_q == fsr_pkg::ST_READ))
    begin
      // first falling edge after loading keeps the msb
      if (skip_q)
        skip_q <= 1'h0;
      else
        tx_q <= {tx_q[6:0], 1'h0};
    end
  end

  // pin and state outputs
  assign o_so             = tx_q[7];
  assign o_so_oe          = (st_q == fsr_pkg::ST_READ) & ~cs_s2_q & ~hold_on;
  assign o_hold_active    = hold_on;
  assign o_pin_reset      = pin_rst;
  assign o_busy           = busy;
  assign o_write_allowed  = wel_q & ~busy;
  assign o_block_protect  = sr_q[fsr_pkg::BP_LSB +: fsr_pkg::BP_W];
  assign o_complement     = sr_q[fsr_pkg::BIT_CMP];
  assign o_info_locks     = sr_q[fsr_pkg::LOCK_LSB +: fsr_pkg::LOCK_W];
  assign o_quad_enable    = sr_q[fsr_pkg::BIT_QUAD];
  assign o_drive_strength = sr_q[fsr_pkg::DRV_LSB +: fsr_pkg::DRV_W];

  // checks on the bank's behaviour
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  same_skip_a: assert property (wr_go & same |=> !nv_busy_q && sr_q == $past(sr_q))
    else $error("identical status write was performed");
  nv_busy_a: assert property (nv_go |=> busy [*8])
    else $error("busy did not hold during status write");
  busy_ign_a: assert property (exec && !ok && !nv_done && !op_fin && !soft_rst
    |=> $stable(wel_q) && $stable(sr_q))
    else $error("command acted while busy");
  susp_flag_a: assert property (exec && op_q == fsr_pkg::OP_SUSPEND && op_run_q && !program_suspended_flag_q
    && !erase_suspended_flag_q && !soft_rst |=> (program_suspended_flag_q ^ erase_suspended_flag_q) && !busy && o_suspend)
    else $error("suspend not taken while running");
  op_done_a: assert property (op_fin && !soft_rst |=> !busy && !wel_q)
    else $error("busy or latch left after finish");
  wel_set_a: assert property (exec && !busy && op_q == fsr_pkg::OP_WRITE_ENABLE
    && !soft_rst |=> wel_q)
    else $error("write enable did not set latch");
  wel_keep_a: assert property (vol_go |=> $stable(wel_q))
    else $error("status write changed latch");
  wel_clr_a: assert property (nv_done |=> !wel_q && sr_q == $past(pend_q))
    else $error("latch not cleared after write");
  rd_vol_a: assert property (byte_done && st_q == fsr_pkg::ST_CMD
    && rx_byte == fsr_pkg::OP_READ_STATUS && !soft_rst |=> tx_q == $past(rd_word[7:0]))
    else $error("read status did not load register one");
  otp_lock_a: assert property ((($past(nv_rdata[13:11]) & ~nv_rdata[13:11]) == 3'h0))
    else $error("lock bit returned to zero");
  pin_role_a: assert property (o_quad_enable |-> !o_hold_active && !o_pin_reset)
    else $error("pin function active with quad on");

  rd_cov_c: cover property (byte_done && st_q == fsr_pkg::ST_READ);
  nv_cov_c: cover property (nv_done);
  vol_cov_c: cover property (vol_go);
  susp_cov_c: cover property (o_suspend ##[1:1000] o_resume);

endmodule
`default_nettype wire

// ---- src/fsr_nv_store.sv ----
// non-volatile copy of the three status bytes
`timescale 1ns/1ps
`default_nettype none
module fsr_nv_store
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // write port, whole word at once
  input  wire logic        i_we,
  input  wire logic [23:0] i_wdata,
  // registered read of all bytes
  output var  logic [23:0] o_rdata
);

  // one cell per status byte
  logic [7:0] mem_q [0:2];

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_byte
      // reset stands in for factory contents
      always_ff @(posedge i_clk)
      begin
        if (i_rst)
          mem_q[g] <= fsr_pkg::SR_RESET[8*g +: 8];
        else if (i_we)
          mem_q[g] <= i_wdata[8*g +: 8];
      end
    end
  endgenerate

  // read data from a register, one cycle behind the cells
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_rdata <= fsr_pkg::SR_RESET;
    else
      o_rdata <= {mem_q[2], mem_q[1], mem_q[0]};
  end

endmodule
`default_nettype wire

// ---- src/fsr_pkg.sv ----
// constants and types shared by the flash status register bank
package fsr_pkg;

  // command codes seen on the serial line
  localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS   = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_VOL_WRITE_EN  = 8'h50;
  localparam logic [7:0] OP_RESET_EN      = 8'h66;
  localparam logic [7:0] OP_SUSPEND       = 8'h75;
  localparam logic [7:0] OP_RESUME        = 8'h7A;
  localparam logic [7:0] OP_RESET         = 8'h99;

  // bit positions in the 24-bit status word
  localparam int BIT_BUSY    = 0;
  localparam int BIT_WEL     = 1;
  localparam int BP_LSB      = 2;
  localparam int BP_W        = 5;
  localparam int BIT_PSEL0   = 7;
  localparam int BIT_PSEL1   = 8;
  localparam int BIT_QUAD    = 9;
  localparam int BIT_PROGRAM_SUSPENDED_FLAG    = 10;
  localparam int LOCK_LSB    = 11;
  localparam int LOCK_W      = 3;
  localparam int BIT_CMP     = 14;
  localparam int BIT_ERASE_SUSPENDED_FLAG    = 15;
  localparam int BIT_ERR     = 19;
  localparam int DRV_LSB     = 21;
  localparam int DRV_W       = 2;
  localparam int BIT_PINSEL  = 23;

  // bits a status write may change, and the one-time lock bits among them
  localparam logic [23:0] WRITE_MASK = 24'hE07BFC;
  localparam logic [23:0] OTP_MASK   = 24'h003800;
  // value after reset: all zero except drive strength at 50 percent
  localparam logic [23:0] SR_RESET   = 24'h400000;

  // timing of an internal non-volatile status write
  localparam int CLK_PERIOD_NS = 100;
  localparam int NV_WRITE_NS   = 2000;
  localparam int NV_WRITE_CYC  = (NV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // serial frame states
  typedef enum logic [4:0]
  {
    ST_IDLE  = 5'b00001,
    ST_CMD   = 5'b00010,
    ST_READ  = 5'b00100,
    ST_WDATA = 5'b01000,
    ST_SKIP  = 5'b10000
  } fsr_state_e;

endpackage
